// ==== core/dcc_pkg.sv ====
// Overview of operation
// - each disable bit gates one port pin
// - disabled port pins always read as zero
// - input-only mode turns pin driver off
// - result high when positive exceeds negative
// - result readable and optionally driven to pin
// - three bits choose one of eight configurations
// - negative input may use internal reference
// - output change sets the change flag
// - interrupt needs flag, enable and global enable
// - flag and result invalid for ten microseconds
// - comparators keep running in low power
// - enabled change in low power wakes processor
// - input disable register at F6h, resets zero
package dcc_pkg;

   // register addresses
   localparam logic [7:0] ADDR_PORT0     = 8'h80;
   localparam logic [7:0] ADDR_P0_MODE1  = 8'h84;
   localparam logic [7:0] ADDR_P0_MODE2  = 8'h85;
   localparam logic [7:0] ADDR_IRQ_CTL_ZERO = 8'hA8;
   localparam logic [7:0] ADDR_CMP_ONE   = 8'hAC;
   localparam logic [7:0] ADDR_CMP_TWO   = 8'hAD;
   localparam logic [7:0] ADDR_IRQ_CTL_ONE = 8'hE8;
   localparam logic [7:0] ADDR_IRQ_STAT  = 8'hF0;
   localparam logic [7:0] ADDR_IRQ_CLR   = 8'hF1;
   localparam logic [7:0] ADDR_IRQ_EN    = 8'hF2;
   localparam logic [7:0] ADDR_P0_INDIS  = 8'hF6;

   // comparator control register fields
   localparam int CTL_FLAG = 0;
   localparam int CTL_RES  = 1;
   localparam int CTL_OE   = 2;
   localparam int CTL_NSEL = 3;
   localparam int CTL_PSEL = 4;
   localparam int CTL_EN   = 5;

   // interrupt enable fields
   localparam int GIE_BIT        = 7;
   localparam int IRQ_EN_CMP_ONE = 5;
   localparam int IRQ_EN_CMP_TWO = 2;

   // port 0 pins that carry comparator results
   localparam int PIN_CMP_ONE = 6;
   localparam int PIN_CMP_TWO = 0;

   // reset values
   localparam logic [7:0] RST_BYTE  = 8'h00;
   localparam logic [7:0] RST_DRIVE = 8'hFF;

   // settling time
   localparam int CLK_PERIOD_NS = 25;
   localparam int SETTLE_NS     = 10000;
   localparam int SETTLE_CYC    = (SETTLE_NS + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;
   localparam int SETTLE_W      = 9;

   typedef enum logic [2:0] {
      DCC_OFF    = 3'b001,
      DCC_SETTLE = 3'b010,
      DCC_RUN    = 3'b100
   } dcc_cmp_state_t;

   typedef struct packed {
      dcc_cmp_state_t      state;
      logic [SETTLE_W-1:0] cnt;
      logic                res;
      logic                change;
      logic                settled;
   } dcc_cmp_st_t;

   typedef struct packed {
      logic [7:0] indis;
      logic [7:0] mode1;
      logic [7:0] mode2;
      logic [7:0] latch;
      logic [1:0] en;
      logic [1:0] psel;
      logic [1:0] nsel;
      logic [1:0] oe;
      logic [1:0] flag;
      logic [1:0] ec;
      logic       gie;
      logic [7:0] rdata;
      logic [7:0] p0_out;
      logic [7:0] p0_oe;
      logic [7:0] p0_read;
      logic       irq;
      logic       wake;
   } dcc_top_st_t;

endpackage

// ==== core/dcc_cmp_if.sv ====
`timescale 1ns/1ps
interface dcc_cmp_if #(
   parameter int AW = 10
);
   logic [AW-1:0] pos_a;
   logic [AW-1:0] pos_b;
   logic [AW-1:0] neg_pin;
   logic [AW-1:0] vref;
   logic          enable;
   logic          psel;
   logic          nsel;
   logic          result;
   logic          change;
   logic          settled;

   modport ctrl (
      output pos_a, pos_b, neg_pin, vref, enable, psel, nsel,
      input  result, change, settled
   );
   modport cmp (
      input  pos_a, pos_b, neg_pin, vref, enable, psel, nsel,
      output result, change, settled
   );
endinterface

// ==== core/dcc_sync.sv ====
`timescale 1ns/1ps
module dcc_sync #(
   parameter int W = 8
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         reset,
   // data
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } dcc_sync_st_t;

   dcc_sync_st_t st_q;
   dcc_sync_st_t st_d;

   always_comb begin
      st_d    = st_q;
      st_d.s1 = d;
      st_d.s2 = st_q.s1;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign q = st_q.s2;
endmodule

// ==== core/dcc_comparator.sv ====
`timescale 1ns/1ps
module dcc_comparator (
   // clock and reset
   input  wire logic clk,
   input  wire logic reset,
   // configuration and result
   dcc_cmp_if.cmp    cif
);
   dcc_pkg::dcc_cmp_st_t st_q;
   dcc_pkg::dcc_cmp_st_t st_d;
   logic                 above;
   logic [$bits(cif.pos_a)-1:0] pos_v;
   logic [$bits(cif.pos_a)-1:0] neg_v;

   localparam logic [dcc_pkg::SETTLE_W-1:0] LAST_CNT =
      dcc_pkg::SETTLE_W'(dcc_pkg::SETTLE_CYC - 1);

   assign pos_v = cif.psel ? cif.pos_b : cif.pos_a;
   assign neg_v = cif.nsel ? cif.vref : cif.neg_pin;
   assign above = pos_v > neg_v;

   always_comb begin
      st_d        = st_q;
      st_d.change = 1'b0;
      unique case (st_q.state)
         dcc_pkg::DCC_OFF: begin
            st_d.res     = 1'b0;
            st_d.settled = 1'b0;
            st_d.cnt     = '0;
            if (cif.enable) begin
               st_d.state = dcc_pkg::DCC_SETTLE;
            end
         end
         dcc_pkg::DCC_SETTLE: begin
            st_d.res = above;
            st_d.cnt = st_q.cnt + 1'b1;
            if (!cif.enable) begin
               st_d.state = dcc_pkg::DCC_OFF;
            end else if (st_q.cnt == LAST_CNT) begin
               st_d.state   = dcc_pkg::DCC_RUN;
               st_d.settled = 1'b1;
            end
         end
         // change detection, runs in any power mode
         dcc_pkg::DCC_RUN: begin
            st_d.res    = above;
            st_d.change = above != st_q.res;
            if (!cif.enable) begin
               st_d.state  = dcc_pkg::DCC_OFF;
               st_d.change = 1'b0;
            end
         end
         default: begin
            st_d.state = dcc_pkg::DCC_OFF;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         st_q       <= '0;
         st_q.state <= dcc_pkg::DCC_OFF;
      end else begin
         st_q <= st_d;
      end
   end

   assign cif.result  = st_q.res;
   assign cif.change  = st_q.change;
   assign cif.settled = st_q.settled;

   property p_settle_len;
      @(posedge clk) disable iff (reset)
      $rose(st_q.settled) |-> $past(st_q.cnt) == LAST_CNT;
   endproperty
   a_settle_len: assert property (p_settle_len)
      else $error("settled before full settling count");

   property p_change_only_run;
      @(posedge clk) disable iff (reset)
      st_q.change |-> st_q.settled && $past(st_q.settled);
   endproperty
   a_change_only_run: assert property (p_change_only_run)
      else $error("change event during settling");

   property p_result_follows;
      @(posedge clk) disable iff (reset)
      (st_q.state == dcc_pkg::DCC_RUN && cif.enable) |=>
         st_q.res == $past(above);
   endproperty
   a_result_follows: assert property (p_result_follows)
      else $error("result does not follow comparison");
endmodule

// ==== core/dcc_top.sv ====
// The implementer's own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
module dcc_top #(
   parameter int AW = 10,
   parameter logic [AW-1:0] VREF_CODE = AW'(328)
) (
   // clock and reset
   input  wire logic          clk,
   input  wire logic          reset,
   // register port
   input  wire logic [7:0]    addr,
   input  wire logic [7:0]    wdata,
   input  wire logic          wr,
   input  wire logic          rd,
   output logic      [7:0]    rdata,
   // port 0 pins
   input  wire logic [7:0]    p0_in,
   output logic      [7:0]    p0_out,
   output logic      [7:0]    p0_oe,
   output logic      [7:0]    p0_read,
   // analog input codes
   input  wire logic [AW-1:0] ana_one_pos_a,
   input  wire logic [AW-1:0] ana_one_pos_b,
   input  wire logic [AW-1:0] ana_two_pos_a,
   input  wire logic [AW-1:0] ana_two_pos_b,
   input  wire logic [AW-1:0] ana_ref_pin,
   // power mode and interrupt
   input  wire logic          low_power,
   output logic               irq,
   output logic               wake
);
   localparam int SW = 8 + 5 * AW + 1;

   dcc_pkg::dcc_top_st_t st_q;
   dcc_pkg::dcc_top_st_t st_d;

   logic [SW-1:0] sync_q;
   logic [7:0]    pin_s;
   logic [AW-1:0] one_pos_a_s;
   logic [AW-1:0] one_pos_b_s;
   logic [AW-1:0] two_pos_a_s;
   logic [AW-1:0] two_pos_b_s;
   logic [AW-1:0] ref_s;
   logic          low_power_s;
   logic [1:0]    res;
   logic [1:0]    chg;
   logic [1:0]    pend;

   dcc_cmp_if #(.AW(AW)) cif_one ();
   dcc_cmp_if #(.AW(AW)) cif_two ();

   // analog codes are assumed to move slowly against the clock
   dcc_sync #(.W(SW)) u_sync (
      .clk   (clk),
      .reset (reset),
      .d     ({p0_in, ana_one_pos_a, ana_one_pos_b, ana_two_pos_a,
               ana_two_pos_b, ana_ref_pin, low_power}),
      .q     (sync_q)
   );

   assign {pin_s, one_pos_a_s, one_pos_b_s, two_pos_a_s, two_pos_b_s,
           ref_s, low_power_s} = sync_q;

   assign cif_one.pos_a   = one_pos_a_s;
   assign cif_one.pos_b   = one_pos_b_s;
   assign cif_one.neg_pin = ref_s;
   assign cif_one.vref    = VREF_CODE;
   assign cif_one.enable  = st_q.en[0];
   assign cif_one.psel    = st_q.psel[0];
   assign cif_one.nsel    = st_q.nsel[0];

   assign cif_two.pos_a   = two_pos_a_s;
   assign cif_two.pos_b   = two_pos_b_s;
   assign cif_two.neg_pin = ref_s;
   assign cif_two.vref    = VREF_CODE;
   assign cif_two.enable  = st_q.en[1];
   assign cif_two.psel    = st_q.psel[1];
   assign cif_two.nsel    = st_q.nsel[1];

   dcc_comparator u_cmp_one (
      .clk   (clk),
      .reset (reset),
      .cif   (cif_one.cmp)
   );

   dcc_comparator u_cmp_two (
      .clk   (clk),
      .reset (reset),
      .cif   (cif_two.cmp)
   );

   assign res  = {cif_two.result, cif_one.result};
   assign chg  = {cif_two.change, cif_one.change};
   // flag, local enable and global enable
   assign pend = st_q.flag & st_q.ec & {2{st_q.gie}};

   function automatic logic [7:0] ctl_byte(input logic i);
      ctl_byte = {2'b00,
                  st_q.en[i],
                  st_q.psel[i],
                  st_q.nsel[i],
                  st_q.oe[i],
                  res[i],
                  st_q.flag[i]};
   endfunction

   function automatic logic [7:0] irq_ctl_byte(input logic [1:0] e);
      irq_ctl_byte                          = 8'h00;
      irq_ctl_byte[dcc_pkg::IRQ_EN_CMP_ONE] = e[0];
      irq_ctl_byte[dcc_pkg::IRQ_EN_CMP_TWO] = e[1];
   endfunction

   always_comb begin
      logic [1:0] clr;
      logic [7:0] rd_v;
      clr  = 2'b00;
      rd_v = 8'h00;
      st_d = st_q;

      if (wr) begin
         unique case (addr)
            dcc_pkg::ADDR_PORT0:    st_d.latch = wdata;
            dcc_pkg::ADDR_P0_MODE1: st_d.mode1 = wdata;
            dcc_pkg::ADDR_P0_MODE2: st_d.mode2 = wdata;
            dcc_pkg::ADDR_IRQ_CTL_ZERO: begin
               st_d.gie = wdata[dcc_pkg::GIE_BIT];
            end
            dcc_pkg::ADDR_IRQ_CTL_ONE: begin
               st_d.ec = {wdata[dcc_pkg::IRQ_EN_CMP_TWO],
                          wdata[dcc_pkg::IRQ_EN_CMP_ONE]};
            end
            dcc_pkg::ADDR_IRQ_EN:   st_d.ec    = wdata[1:0];
            // write-one clear register, extra to the flag bit
            dcc_pkg::ADDR_IRQ_CLR:  clr        = wdata[1:0];
            dcc_pkg::ADDR_P0_INDIS: st_d.indis = wdata;
            dcc_pkg::ADDR_CMP_ONE, dcc_pkg::ADDR_CMP_TWO: begin
               st_d.en[addr[0]]   = wdata[dcc_pkg::CTL_EN];
               st_d.psel[addr[0]] = wdata[dcc_pkg::CTL_PSEL];
               st_d.nsel[addr[0]] = wdata[dcc_pkg::CTL_NSEL];
               st_d.oe[addr[0]]   = wdata[dcc_pkg::CTL_OE];
               // a written zero clears the flag, a written one leaves it
               clr[addr[0]]       = ~wdata[dcc_pkg::CTL_FLAG];
            end
            default: begin
            end
         endcase
      end

      // set wins over a clear in the same cycle
      st_d.flag = (st_q.flag & ~clr) | chg;

      if (rd) begin
         unique case (addr)
            dcc_pkg::ADDR_PORT0:    rd_v = pin_s & ~st_q.indis;
            dcc_pkg::ADDR_P0_MODE1: rd_v = st_q.mode1;
            dcc_pkg::ADDR_P0_MODE2: rd_v = st_q.mode2;
            dcc_pkg::ADDR_IRQ_CTL_ZERO: rd_v = {st_q.gie, 7'h00};
            dcc_pkg::ADDR_IRQ_CTL_ONE:  rd_v = irq_ctl_byte(st_q.ec);
            dcc_pkg::ADDR_IRQ_STAT: rd_v = {6'h00, st_q.flag};
            dcc_pkg::ADDR_IRQ_EN:   rd_v = {6'h00, st_q.ec};
            dcc_pkg::ADDR_P0_INDIS: rd_v = st_q.indis;
            dcc_pkg::ADDR_CMP_ONE:  rd_v = ctl_byte(1'b0);
            dcc_pkg::ADDR_CMP_TWO:  rd_v = ctl_byte(1'b1);
            default:                rd_v = 8'h00;
         endcase
      end
      st_d.rdata = rd_v;

      // digital input path gated per pin
      st_d.p0_read = pin_s & ~st_q.indis;

      st_d.p0_oe  = ~(st_q.mode1 & ~st_q.mode2);
      st_d.p0_out = st_q.latch;
      // result drives its pin when enabled
      if (st_q.oe[0]) begin
         st_d.p0_out[dcc_pkg::PIN_CMP_ONE] = res[0];
      end
      if (st_q.oe[1]) begin
         st_d.p0_out[dcc_pkg::PIN_CMP_TWO] = res[1];
      end

      st_d.irq  = |pend;
      // wake from idle or power down
      st_d.wake = low_power_s & (|pend);
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         st_q       <= '0;
         st_q.indis <= dcc_pkg::RST_BYTE;
         st_q.p0_oe <= dcc_pkg::RST_DRIVE;
      end else begin
         st_q <= st_d;
      end
   end

   assign rdata   = st_q.rdata;
   assign p0_out  = st_q.p0_out;
   assign p0_oe   = st_q.p0_oe;
   assign p0_read = st_q.p0_read;
   assign irq     = st_q.irq;
   assign wake    = st_q.wake;

   default clocking dcc_cb @(posedge clk);
   endclocking
   default disable iff (reset);

   property p_masked_read;
      ##1 ((p0_read & $past(st_q.indis)) == 8'h00);
   endproperty
   a_masked_read: assert property (p_masked_read)
      else $error("disabled port pin read as one");

   property p_irq_gate;
      ##1 (irq == $past(st_q.gie && |(st_q.flag & st_q.ec)));
   endproperty
   a_irq_gate: assert property (p_irq_gate)
      else $error("interrupt not gated by flag and enables");

   property p_flag_set;
      chg[0] |=> st_q.flag[0] ##1 (st_q.flag[0] || $past(wr));
   endproperty
   a_flag_set: assert property (p_flag_set)
      else $error("change did not set flag");

   property p_flag_cause;
      $rose(st_q.flag[1]) |-> $past(chg[1]);
   endproperty
   a_flag_cause: assert property (p_flag_cause)
      else $error("flag set without a change event");

   property p_flag_clear;
      (wr && addr == dcc_pkg::ADDR_CMP_ONE &&
       !wdata[dcc_pkg::CTL_FLAG] && !chg[0]) |=> !st_q.flag[0];
   endproperty
   a_flag_clear: assert property (p_flag_clear)
      else $error("written zero did not clear flag");

   property p_indis_reset;
      $fell(reset) |-> st_q.indis == dcc_pkg::RST_BYTE;
   endproperty
   a_indis_reset: assert property (p_indis_reset)
      else $error("input disable not zero after reset");

   property p_driver_off;
      ##1 (p0_oe == $past(~(st_q.mode1 & ~st_q.mode2)));
   endproperty
   a_driver_off: assert property (p_driver_off)
      else $error("driver on in input-only mode");

   property p_pin_result;
      st_q.oe[0] |=> p0_out[dcc_pkg::PIN_CMP_ONE] == $past(res[0]);
   endproperty
   a_pin_result: assert property (p_pin_result)
      else $error("comparator pin does not carry result");

   property p_wake;
      (low_power_s && st_q.gie && |(st_q.flag & st_q.ec)) |=> wake;
   endproperty
   a_wake: assert property (p_wake)
      else $error("no wake on enabled change in low power");

   property p_wake_gate;
      wake |-> $past(low_power_s);
   endproperty
   a_wake_gate: assert property (p_wake_gate)
      else $error("wake raised outside low power");

   property p_pin_result_two;
      st_q.oe[1] |=> p0_out[dcc_pkg::PIN_CMP_TWO] == $past(res[1]);
   endproperty
   a_pin_result_two: assert property (p_pin_result_two)
      else $error("comparator two pin does not carry result");

   property p_flag_cause_one;
      $rose(st_q.flag[0]) |-> $past(chg[0]);
   endproperty
   a_flag_cause_one: assert property (p_flag_cause_one)
      else $error("flag one set without a change event");

   property p_flag_set_two;
      chg[1] |=> st_q.flag[1];
   endproperty
   a_flag_set_two: assert property (p_flag_set_two)
      else $error("change did not set flag two");

   property p_read_path;
      ##1 (p0_read == $past(pin_s & ~st_q.indis));
   endproperty
   a_read_path: assert property (p_read_path)
      else $error("digital input path not gated per pin");

   property p_port_read;
      (rd && addr == dcc_pkg::ADDR_PORT0) |=>
         (rdata & $past(st_q.indis)) == 8'h00;
   endproperty
   a_port_read: assert property (p_port_read)
      else $error("port read shows a disabled pin as one");
endmodule

// ==== dv/dcc_analog_model.sv ====
`timescale 1ns/1ps
module dcc_analog_model #(
   parameter int AW = 10
) (
   // clock
   input  wire logic               clk,
   // requested levels and outside pin drive
   input  wire logic [4:0][AW-1:0] lvl,
   input  wire logic [7:0]         ext_pin,
   // device pin drive
   input  wire logic [7:0]         p0_out,
   input  wire logic [7:0]         p0_oe,
   // what the device sees
   output logic      [4:0][AW-1:0] ana,
   output logic      [7:0]         p0_in
);
   // source impedance: a new level lands one edge late
   always_ff @(posedge clk) begin
      ana <= lvl;
   end
   // wire level: device drive wins where it is enabled
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         p0_in[i] = p0_oe[i] ? p0_out[i] : ext_pin[i];
      end
   end
endmodule

// ==== dv/dual_comparator_control_tb.sv ====
`timescale 1ns/1ps
module dual_comparator_control_tb;
   logic             clk, reset, wr, rd, low_power, irq, wake;
   logic [7:0]       addr, wdata, rdata, p0_in, p0_out, p0_oe, p0_read;
   logic [7:0]       ext, d, dis;
   logic [4:0][9:0]  lv, ana, nl;
   int               n_mismatch, num_checks, seed;

   dcc_top dcc_top_inst (.clk(clk), .reset(reset), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .p0_in(p0_in),
      .p0_out(p0_out), .p0_oe(p0_oe), .p0_read(p0_read),
      .ana_one_pos_a(ana[0]), .ana_one_pos_b(ana[1]),
      .ana_two_pos_a(ana[2]), .ana_two_pos_b(ana[3]),
      .ana_ref_pin(ana[4]), .low_power(low_power),
      .irq(irq), .wake(wake));
   dcc_analog_model dcc_analog_model_inst (.clk(clk), .lvl(lv),
      .ext_pin(ext), .p0_out(p0_out), .p0_oe(p0_oe), .ana(ana),
      .p0_in(p0_in));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   function automatic logic exp_res(int c, logic ps, logic ns);
      logic [9:0] p, n;
      p = ps ? lv[2*c+1] : lv[2*c];
      n = ns ? 10'h148 : lv[4];
      return p > n;
   endfunction

   task automatic check(logic [7:0] got, logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // extra idle edge: a following output sample sees what the write launched
   task automatic wr_reg(logic [7:0] a, logic [7:0] v);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
      @(posedge clk);
   endtask

   task automatic rd_reg(logic [7:0] a, output logic [7:0] v);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 v = rdata;
      @(posedge clk);
   endtask

   task automatic conclude();
      $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   initial begin
      #(25ns * 20000);
      n_mismatch++;
      conclude();
   end

   initial begin
      seed = 45247;
      reset = 1'b1;
      wr = 1'b0;
      rd = 1'b0;
      addr = 8'h00;
      wdata = 8'h00;
      low_power = 1'b0;
      ext = 8'h00;
      lv = '0;
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      check(p0_oe, 8'hFF);
      rd_reg(8'hF6, d);
      check(d, 8'h00);
      wr_reg(8'h99, 8'h5A);
      rd_reg(8'h99, d);
      check(d, 8'h00);
      // input-only mode on every pin
      wr_reg(8'h84, 8'hFF);
      wr_reg(8'h85, 8'h00);
      check(p0_oe, 8'h00);
      for (int i = 0; i < 6; i++) begin
         dis = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($random(seed));
         ext <= 8'($random(seed));
         wr_reg(8'hF6, dis);
         repeat (4) @(posedge clk);
         check(p0_read, ext & ~dis);
         rd_reg(8'h80, d);
         check(d, ext & ~dis);
         rd_reg(8'hF6, d);
         check(d, dis);
      end
      wr_reg(8'hAC, 8'h20);
      wr_reg(8'hAD, 8'h20);
      repeat (410) @(posedge clk);
      for (int c = 0; c < 2; c++) begin
         for (int cfg = 0; cfg < 8; cfg++) begin
            for (int k = 0; k < 5; k++) begin
               nl[k] = 10'($random(seed));
            end
            // equal inputs must give a zero result
            if (cfg == 0) begin
               nl[4] = nl[2*c];
            end
            lv <= nl;
            wr_reg(8'hAC + 8'(c), 8'h20 | 8'(cfg << 2));
            repeat (8) @(posedge clk);
            rd_reg(8'hAC + 8'(c), d);
            check(d & 8'h3E, {3'b001, 3'(cfg),
               exp_res(c, cfg[2], cfg[1]), 1'b0});
            if (cfg[0]) begin
               check(8'(p0_out[c == 0 ? 6 : 0]),
                  8'(exp_res(c, cfg[2], cfg[1])));
            end
         end
      end
      // flag cleared before the interrupt is enabled
      lv[0] <= 10'd100;
      lv[4] <= 10'd200;
      wr_reg(8'hAC, 8'h20);
      repeat (8) @(posedge clk);
      wr_reg(8'hAC, 8'h20);
      wr_reg(8'hF1, 8'h03);
      wr_reg(8'hA8, 8'h80);
      wr_reg(8'hE8, 8'h20);
      check(8'(irq), 8'h00);
      rd_reg(8'hE8, d);
      check(d, 8'h20);
      rd_reg(8'hA8, d);
      check(d, 8'h80);
      lv[0] <= 10'd300;
      repeat (10) @(posedge clk);
      check(8'(irq), 8'h01);
      rd_reg(8'hF0, d);
      check(d & 8'h01, 8'h01);
      wr_reg(8'hAC, 8'h21);
      repeat (50) @(posedge clk);
      rd_reg(8'hAC, d);
      check(d & 8'h03, 8'h03);
      wr_reg(8'hA8, 8'h00);
      check(8'(irq), 8'h00);
      wr_reg(8'hA8, 8'h80);
      wr_reg(8'hF2, 8'h00);
      check(8'(irq), 8'h00);
      wr_reg(8'hF2, 8'h01);
      check(8'(irq), 8'h01);
      rd_reg(8'hF2, d);
      check(d, 8'h01);
      wr_reg(8'hAC, 8'h20);
      check(8'(irq), 8'h00);
      low_power <= 1'b1;
      lv[0] <= 10'd50;
      repeat (12) @(posedge clk);
      check(8'(wake), 8'h01);
      rd_reg(8'hAC, d);
      check(d & 8'h03, 8'h01);
      wr_reg(8'hF1, 8'h01);
      check({irq, wake}, 2'b00);
      low_power <= 1'b0;
      // settling window hides changes of comparator two
      lv[2] <= 10'd0;
      wr_reg(8'hAD, 8'h00);
      wr_reg(8'hF1, 8'h02);
      wr_reg(8'hAD, 8'h20);
      repeat (20) @(posedge clk);
      lv[2] <= 10'h3FF;
      repeat (10) @(posedge clk);
      rd_reg(8'hF0, d);
      check(d & 8'h02, 8'h00);
      repeat (400) @(posedge clk);
      lv[2] <= 10'd0;
      repeat (10) @(posedge clk);
      rd_reg(8'hF0, d);
      check(d & 8'h02, 8'h02);
      conclude();
   end
endmodule
